/* File: kli_consts.vh */
`ifndef KLI_CONSTS_VH
`define KLI_CONSTS_VH
// Register addresses in SFR space
`define KLI_ADDR_CONTROL 8'ha3
`define KLI_ADDR_STATUS 8'ha4
// Reset values
`define KLI_CONTROL_RST 8'h0f
`define KLI_STATUS_RST 8'h00
`define KLI_NIB_ZERO 4'h0
`define KLI_NIB_ONES 4'hf
`define KLI_BIT_ZERO 1'h0
`define KLI_BYTE_ZERO 8'h00
`define KLI_RSVD_ZERO 3'h0
// Field positions
`define KLI_LEVEL_HI 7
`define KLI_LEVEL_LO 4
`define KLI_MASK_HI 3
`define KLI_MASK_LO 0
`define KLI_WAKE_BIT 7
`define KLI_FLAG_HI 3
`define KLI_FLAG_LO 0
`endif

/* File: kli_sync.v */
`timescale 1ns/1ns
`include "kli_consts.vh"
// ****************************************
// Two-stage synchroniser for keypad inputs
// ****************************************
module kli_sync (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [3:0] i_async,
  output reg [3:0] o_sync
);
  reg [3:0] meta_reg;

  // First stage feeds only the second stage
  // Reset to the pulled-up idle level; a zero here would look like
  // a low-level key hit on every input just after reset
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_reg <= `KLI_NIB_ONES;
      o_sync <= `KLI_NIB_ONES;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

/* File: kli_keypad.v */
`timescale 1ns/1ns
`include "kli_consts.vh"
// Notes on behaviour
// (R1) Level select bit: one high, zero low
// (R2) Mask bit one blocks that flag's request
// (R3) Control resets to 0x0f
// (R4) Wake enable lets request end power-down
// (R5) Status bits six to four read zero
// (R6) Flags set on level; status read clears
// (R7) Status resets to all zeros
// (R8) Request is OR of unmasked flags
// (R9) Global enable gates combined request
// (R10) Detection can end idle and power-down
// (R11) Inputs synchronised two stages before compare
module kli_keypad (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [3:0] i_keypad_inputs,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_rd,
  input wire i_keyboard_irq_global_enable,
  output reg [7:0] o_sfr_rdata,
  output reg o_keyboard_irq,
  output reg o_idle_wake,
  output reg o_powerdown_wake
);
  // ****************************************
  // Storage
  // ****************************************
  reg [7:0] keypad_control_reg;
  reg [7:0] keypad_control_next;
  reg powerdown_wake_enable_reg;
  reg powerdown_wake_enable_next;
  reg [3:0] input_detect_flag_reg;
  reg [3:0] input_detect_flag_next;
  reg [7:0] rdata_next;
  wire [3:0] keypad_sync;
  wire [3:0] input_level_select;
  wire [3:0] input_irq_mask;
  wire [3:0] level_hit;
  wire [3:0] unmasked_flags;
  wire wr_control;
  wire wr_status;
  wire rd_status;
  wire request;
  wire request_gated;
  wire powerdown_request;

  // ****************************************
  // Helper functions
  // ****************************************

  // Full-byte address compare; shared by strobe decode and read mux
  function kli_addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      kli_addr_hit = (addr == target);
    end
  endfunction

  // Per-input match of the synchronised pin against its selected level
  function [3:0] kli_level_match;
    input [3:0] pins;
    input [3:0] level_sel;
    begin
      // XNOR: a one where the pin equals the selected level
      kli_level_match = ~(pins ^ level_sel);
    end
  endfunction

  // Status byte; reserved bits forced low whatever was written
  function [7:0] kli_status_word;
    input wake;
    input [3:0] flags;
    begin
      kli_status_word = {wake, `KLI_RSVD_ZERO, flags};
    end
  endfunction

  // ****************************************
  // Input synchroniser
  // ****************************************

  // Keeps the level compare away from raw pins
  // Costs two cycles of latency from pin to flag
  kli_sync kli_sync_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_keypad_inputs),
    .o_sync(keypad_sync)
  ); // [R11]

  // ****************************************
  // Decode and detection
  // ****************************************

  // Strobes qualified by full address; other SFRs pass untouched
  assign wr_control = i_sfr_wr && kli_addr_hit(i_sfr_addr, `KLI_ADDR_CONTROL);
  assign wr_status = i_sfr_wr && kli_addr_hit(i_sfr_addr, `KLI_ADDR_STATUS);
  assign rd_status = i_sfr_rd && kli_addr_hit(i_sfr_addr, `KLI_ADDR_STATUS);

  // Control fields
  assign input_level_select = keypad_control_reg[`KLI_LEVEL_HI:`KLI_LEVEL_LO];
  assign input_irq_mask = keypad_control_reg[`KLI_MASK_HI:`KLI_MASK_LO];

  // Level detect, not edge: a held key keeps re-setting its flag
  assign level_hit = kli_level_match(keypad_sync, input_level_select); // [R1]

  // Masked flags still set and read back; they only stay quiet
  assign unmasked_flags = input_detect_flag_reg & ~input_irq_mask; // [R2]
  assign request = |unmasked_flags; // [R8]

  // Global enable sits in front of every consumer of the request
  assign request_gated = request && i_keyboard_irq_global_enable; // [R9]
  assign powerdown_request = request_gated && powerdown_wake_enable_reg; // [R4]

  // ****************************************
  // Next-state logic
  // ****************************************

  // Control is plain read/write storage
  always @* begin
    keypad_control_next = keypad_control_reg;
    if (wr_control) begin
      keypad_control_next = i_sfr_wdata;
    end
  end

  // Flags are hardware-owned; a status write only touches wake enable
  always @* begin
    powerdown_wake_enable_next = powerdown_wake_enable_reg;
    if (wr_status) begin
      powerdown_wake_enable_next = i_sfr_wdata[`KLI_WAKE_BIT]; // [R4]
    end
  end

  // Set wins over read clear so no key press is lost
  always @* begin
    input_detect_flag_next = input_detect_flag_reg;
    if (rd_status) begin
      input_detect_flag_next = `KLI_NIB_ZERO; // [R6]
    end
    input_detect_flag_next = input_detect_flag_next | level_hit; // [R6]
  end

  // Read mux; unmapped addresses return zero
  always @* begin
    rdata_next = `KLI_BYTE_ZERO;
    if (kli_addr_hit(i_sfr_addr, `KLI_ADDR_CONTROL)) begin
      rdata_next = keypad_control_reg;
    end else if (kli_addr_hit(i_sfr_addr, `KLI_ADDR_STATUS)) begin
      rdata_next = kli_status_word(powerdown_wake_enable_reg, input_detect_flag_reg); // [R5]
    end
  end

  // ****************************************
  // Registers
  // ****************************************

  // Every input starts low-detecting and masked
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      keypad_control_reg <= `KLI_CONTROL_RST; // [R3]
    end else begin
      keypad_control_reg <= keypad_control_next;
    end
  end

  // Wake enable off after reset
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      powerdown_wake_enable_reg <= `KLI_BIT_ZERO; // [R7]
    end else begin
      powerdown_wake_enable_reg <= powerdown_wake_enable_next;
    end
  end

  // No flag pending after reset
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      input_detect_flag_reg <= `KLI_NIB_ZERO; // [R7]
    end else begin
      input_detect_flag_reg <= input_detect_flag_next;
    end
  end

  // Read data registered every cycle; it shows pre-clear status
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= `KLI_BYTE_ZERO;
    end else begin
      o_sfr_rdata <= rdata_next;
    end
  end

  // ****************************************
  // Interrupt and wake outputs
  // ****************************************

  // Registered, so the core sees a request one cycle after the flag
  // Power-down exit also needs wake enable; idle exit does not
  // Limitation: with the clock stopped nothing here samples the pins
  always @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_keyboard_irq <= `KLI_BIT_ZERO;
      o_idle_wake <= `KLI_BIT_ZERO;
      o_powerdown_wake <= `KLI_BIT_ZERO;
    end else begin
      o_keyboard_irq <= request_gated; // [R9]
      o_idle_wake <= request_gated; // [R10]
      o_powerdown_wake <= powerdown_request; // [R4] [R10]
    end
  end
endmodule

/* File: kli_keys.sv */
`timescale 1ns/1ns
// ****
// Keys
// ****
module kli_keys (
  input wire [3:0] i_press,
  output wire [3:0] o_keys
);
  // Pull-ups keep idle lines high, a press pulls low
  // Follows the press at once, so no race with the bench's own edge
  assign o_keys = ~i_press;
endmodule

/* File: kli_keypad_sva.sv */
`timescale 1ns/1ns
// *******
// Checker
// *******
module kli_keypad_sva (
  input wire i_mclk,
  input wire i_rst_n,
  input wire [3:0] i_keypad_inputs,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire [7:0] i_sfr_wdata,
  input wire i_sfr_rd,
  input wire i_keyboard_irq_global_enable,
  input wire [7:0] o_sfr_rdata,
  input wire o_keyboard_irq,
  input wire o_idle_wake,
  input wire o_powerdown_wake
);
  wire [7:0] a = i_sfr_addr;
  wire [7:0] d = o_sfr_rdata;
  wire q = o_keyboard_irq;
  wire p = o_powerdown_wake;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  a_idle_same: assert property (o_idle_wake == q) else $error("idle wake");
  a_pd_gate: assert property (p |-> q) else $error("pd wake");
  a_global_gate: assert property (!$past(i_keyboard_irq_global_enable) |-> !q) else $error("gate");
  a_rsvd_zero: assert property ($past(a) == 8'ha4 |-> d[6:4] == 3'h0) else $error("rsvd");
  a_mask_block: assert property ($past(a) == 8'ha3 && d[3:0] == 4'hf |-> !q) else $error("mask");
  a_pd_off: assert property ($past(a) == 8'ha4 && !d[7] |-> !p) else $error("pd off");
  a_irq_fall: assert property (
    $fell(q) |-> $past(i_sfr_rd | i_sfr_wr, 2) || !$past(i_keyboard_irq_global_enable)) else $error("irq fell");
  a_ctrl_write: assert property (
    i_sfr_wr && a == 8'ha3 ##1 a == 8'ha3 |=> d == $past(i_sfr_wdata, 2)) else $error("ctl wr");
  a_wake_bit: assert property (
    i_sfr_wr && a == 8'ha4 ##1 a == 8'ha4 |=> d[7] == $past(i_sfr_wdata[7], 2)) else $error("wake wr");
  c_irq: cover property (q);
  c_pd: cover property (p);
  c_fall: cover property ($fell(q));
endmodule
bind kli_keypad kli_keypad_sva kli_keypad_sva_i(.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_keypad_inputs(i_keypad_inputs), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
  .i_sfr_rd(i_sfr_rd), .i_keyboard_irq_global_enable(i_keyboard_irq_global_enable), .o_sfr_rdata(o_sfr_rdata),
  .o_keyboard_irq(o_keyboard_irq), .o_idle_wake(o_idle_wake), .o_powerdown_wake(o_powerdown_wake));

/* File: kli_keypad_test.sv */
`timescale 1ns/1ns
// *****
// Bench
// *****
module kli_keypad_test;
  reg i_mclk = 0, i_rst_n = 0, wr = 0, rdn = 0, en = 1;
  reg [7:0] ad = 0, wd = 0;
  reg [3:0] press = 0;
  wire [3:0] keys;
  wire [7:0] rdata;
  wire irq, idle, pd;
  integer num_errors = 0, n_compared = 0, cyc = 0;
  kli_keys kli_keys_i(.i_press(press), .o_keys(keys));
  kli_keypad kli_keypad_i(.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_keypad_inputs(keys), .i_sfr_addr(ad),
    .i_sfr_wr(wr), .i_sfr_wdata(wd), .i_sfr_rd(rdn), .i_keyboard_irq_global_enable(en),
    .o_sfr_rdata(rdata), .o_keyboard_irq(irq), .o_idle_wake(idle), .o_powerdown_wake(pd));
  initial forever #2 i_mclk = ~i_mclk;
  // Hang guard, run needs under 70 cycles
  always @(posedge i_mclk) if (++cyc > 2000) begin num_errors++; final_report; end
  task final_report;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [7:0] seen, input [7:0] exp, input string n);
    n_compared++;
    if (seen !== exp) begin num_errors++; $display("Error %s exp %h seen %h", n, exp, seen); end
  endtask
  // One strobe cycle; address is left in place so read data keeps tracking it
  task acc(input [7:0] a, input w, input [7:0] d);
    @(negedge i_mclk) {ad, wr, rdn, wd} = {a, w, !w, d};
    @(negedge i_mclk) {wr, rdn} = 2'h0;
  endtask
  task rd(input [7:0] a, input [7:0] e, input string n);
    acc(a, 0, 8'h00);
    chk(rdata, e, n);
  endtask
  task key(input [3:0] k);
    press = k;
    repeat (6) @(negedge i_mclk);
    press = 0;
    repeat (6) @(negedge i_mclk);
  endtask
  task tick;
    repeat (2) @(negedge i_mclk);
  endtask
  initial begin
    repeat (3) @(negedge i_mclk);
    i_rst_n = 1;
    rd(8'ha3, 8'h0f, "ctl");
    rd(8'ha4, 8'h00, "sta");
    rd(8'h5a, 8'h00, "gap");
    acc(8'ha3, 1, 8'h00);
    key(4'h4);
    chk(irq, 8'h01, "irq");
    rd(8'ha4, 8'h04, "flg");
    rd(8'ha4, 8'h00, "clr");
    chk(irq, 8'h00, "irq");
    acc(8'ha3, 1, 8'h04);
    key(4'h4);
    chk(irq, 8'h00, "msk");
    acc(8'ha3, 1, 8'h00);
    tick;
    chk(irq, 8'h01, "unm");
    chk(pd, 8'h00, "pd");
    chk(idle, 8'h01, "idl");
    en = 0;
    tick;
    chk(irq, 8'h00, "gen");
    en = 1;
    acc(8'ha4, 1, 8'hf0);
    tick;
    chk(pd, 8'h01, "pd");
    rd(8'ha4, 8'h84, "rsv");
    acc(8'ha3, 1, 8'h10);
    tick;
    rd(8'ha4, 8'h81, "hi");
    // Mid-run reset while a level is still matching
    i_rst_n = 0;
    repeat (3) @(negedge i_mclk);
    i_rst_n = 1;
    rd(8'ha3, 8'h0f, "ctl2");
    rd(8'ha4, 8'h00, "sta2");
    final_report;
  end
endmodule
